// *** rtl/supply_mode_regs.svh ***
`ifndef SUPPLY_MODE_REGS_SVH
`define SUPPLY_MODE_REGS_SVH

// operating-mode status field encodings
`define MODE_FIELD_IDLE 2'h0
`define MODE_FIELD_LIMP 2'h1
`define MODE_FIELD_ACTIVE 2'h2
`define MODE_FIELD_SLEEP 2'h3

// channels that limp home may drive (bit mask over eight channels)
`define LIMP_CHANNEL_MASK 8'h0C

// default input mapping: input 0 drives channel 2, input 1 drives channel 3
`define MAP_A_DEFAULT 8'h04
`define MAP_B_DEFAULT 8'h08

// reset values
`define OUTPUT_ON_DEFAULT 8'h00
`define OPEN_LOAD_OFF_DEFAULT 8'h00
`define FLAG_DEFAULT 1'b0

// cycles a mode change takes before channels may turn on
`define MODE_SETTLE_NS 40
`define MODE_SETTLE_CYCLES ((`MODE_SETTLE_NS + 7) / 8)

`endif

// *** rtl/supply_mode_pkg.sv ***
package supply_mode_pkg;
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_ACTIVE = 2'b10,
    MODE_LIMP = 2'b11
  } op_mode_t;

  typedef logic [7:0] chan_vec_t;
endpackage

// *** rtl/sync_bus_if.sv ***
`timescale 1ns/1ps
interface sync_bus_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface // sync_bus_if

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  sync_bus_if.sync_side bus
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage1_d;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage2_d;

  always_comb begin
    stage1_d = bus.raw;
    stage2_d = stage1_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign bus.synced = stage2_q;
endmodule // pin_sync

// *** rtl/supply_mode_controller.sv ***
`timescale 1ns/1ps
`include "supply_mode_regs.svh"

// Function
// (R1) idle high and any input or output-on bit high enters active
// (R2) stay-active clear: active returns to idle once inputs and bits clear
// (R3) stay-active set: active holds even with all inputs low
// (R4) any high input counts for active regardless of input mapping
// (R5) idle low with an input high enters limp home, driving mapped channel
// (R6) limp home: serial reads answered, all serial writes ignored
// (R7) limp home: supply flags held at one, open-load-off bits held zero
// (R8) limp home reports mode field as binary 01
// (R9) transmission error set in first response after entering limp home
// (R10) limp home: error and monitor bits normal, other registers default
// (R11) limp home: only channels 2 and 3 may turn on
// (R12) host avoids serial commands during active and limp home changes
// (R13) turn-on from other modes waits for the mode transition
// (R14) registers reset on logic undervoltage, idle low, or reset command
// (R15) reset command keeps the channel error bits
// (R16) reset command clears both supply flags
// (R17) register reset restores mapping; channels off unless held by input
// (R18) analog undervoltage while operative sets supply undervoltage flag
// (R19) supply undervoltage flag clears on diagnosis readout after recovery
// (R20) low-operating flag set in range, cleared on readout after recovery
// (R21) sleep keeps outputs off and registers in reset
// (R22) idle keeps outputs off, registers usable, error bits kept
// (R23) pins and comparators synchronised before mode decisions
module supply_mode_controller #(
  parameter int CHANNELS = 8,
  parameter int INPUTS = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic idle_pin,
  input wire logic [INPUTS-1:0] parallel_input_pins,
  input wire logic logic_supply_ok,
  input wire logic logic_low_operating,
  input wire logic analog_supply_uv,
  input wire logic analog_supply_op,
  input wire logic reg_write,
  input wire logic [CHANNELS-1:0] wr_output_on_bits,
  input wire logic wr_stay_active_bit,
  input wire logic wr_reset_command_bit,
  input wire logic [CHANNELS-1:0] wr_input_map_reg_a,
  input wire logic [CHANNELS-1:0] wr_input_map_reg_b,
  input wire logic [CHANNELS-1:0] wr_open_load_off_bits,
  input wire logic serial_command,
  input wire logic diag_readout,
  input wire logic [CHANNELS-1:0] channel_error_set,
  input wire logic transmission_error_event,
  output supply_mode_pkg::op_mode_t mode,
  output logic [1:0] mode_field,
  output logic [CHANNELS-1:0] channel_on,
  output logic [CHANNELS-1:0] output_on_bits,
  output logic stay_active_bit,
  output logic [CHANNELS-1:0] input_map_reg_a,
  output logic [CHANNELS-1:0] input_map_reg_b,
  output logic [CHANNELS-1:0] open_load_off_bits,
  output logic [CHANNELS-1:0] channel_error_bits,
  output logic [CHANNELS-1:0] output_status_monitor_bits,
  output logic supply_undervoltage_flag,
  output logic logic_low_operating_flag,
  output logic transmission_error_flag,
  output logic regs_in_reset
);
  import supply_mode_pkg::*;

  localparam int SW = INPUTS + 5;
  localparam int SETTLE = `MODE_SETTLE_CYCLES;
  localparam int CW = $clog2(SETTLE + 1);

  function automatic logic [CHANNELS-1:0] map_inputs(
    input logic [INPUTS-1:0] pins,
    input logic [CHANNELS-1:0] map_a,
    input logic [CHANNELS-1:0] map_b
  );
    logic [CHANNELS-1:0] r;
    r = '0;
    if (pins[0]) begin
      r = r | map_a;
    end
    if (INPUTS > 1 && pins[INPUTS-1]) begin
      r = r | map_b;
    end
    return r;
  endfunction

  // synchronise pins and comparators
  sync_bus_if #(.WIDTH(SW)) sync_bus ();
  assign sync_bus.raw = {idle_pin, parallel_input_pins, logic_supply_ok,
    logic_low_operating, analog_supply_uv, analog_supply_op};

  pin_sync #(.WIDTH(SW)) u_sync ( // (R23)
    .clk(clk),
    .reset(reset),
    .bus(sync_bus)
  );

  logic idle_s;
  logic [INPUTS-1:0] in_s;
  logic vdd_ok_s;
  logic vdd_lop_s;
  logic vs_uv_s;
  logic vs_op_s;
  assign {idle_s, in_s, vdd_ok_s, vdd_lop_s, vs_uv_s, vs_op_s} =
    sync_bus.synced;

  // mode state
  op_mode_t mode_q;
  op_mode_t mode_d;
  logic [CW-1:0] settle_q;
  logic [CW-1:0] settle_d;
  logic limp_first_q;
  logic limp_first_d;

  // register bank
  logic [CHANNELS-1:0] out_on_q;
  logic [CHANNELS-1:0] out_on_d;
  logic act_q;
  logic act_d;
  logic [CHANNELS-1:0] map_a_q;
  logic [CHANNELS-1:0] map_a_d;
  logic [CHANNELS-1:0] map_b_q;
  logic [CHANNELS-1:0] map_b_d;
  logic [CHANNELS-1:0] open_load_off_bits_q;
  logic [CHANNELS-1:0] open_load_off_bits_d;
  logic [CHANNELS-1:0] err_q;
  logic [CHANNELS-1:0] err_d;
  logic uv_q;
  logic uv_d;
  logic lop_q;
  logic lop_d;
  logic ter_q;
  logic ter_d;
  logic [CHANNELS-1:0] chan_q;
  logic [CHANNELS-1:0] chan_d;
  logic [1:0] field_q;
  logic [1:0] field_d;
  logic rst_q;
  logic rst_d;

  logic any_in;
  logic any_out;
  logic bank_reset;
  logic cmd_reset;
  logic wr_ok;

  always_comb begin
    any_in = |in_s; // (R4)
    any_out = |out_on_q;
    mode_d = mode_q;
    case (mode_q)
      MODE_SLEEP: begin
        if (idle_s && (any_in || any_out)) begin
          mode_d = MODE_ACTIVE; // (R1)
        end else if (idle_s) begin
          mode_d = MODE_IDLE;
        end else if (any_in) begin
          mode_d = MODE_LIMP; // (R5)
        end
      end
      MODE_IDLE: begin
        if (!idle_s) begin
          mode_d = any_in ? MODE_LIMP : MODE_SLEEP; // (R5)
        end else if (any_in || any_out) begin
          mode_d = MODE_ACTIVE; // (R1)
        end
      end
      MODE_ACTIVE: begin
        if (!idle_s) begin
          mode_d = any_in ? MODE_LIMP : MODE_SLEEP;
        end else if (!act_q && !any_in && !any_out) begin
          mode_d = MODE_IDLE; // (R2) (R3)
        end
      end
      MODE_LIMP: begin
        if (idle_s) begin
          mode_d = (any_in || any_out) ? MODE_ACTIVE : MODE_IDLE;
        end else if (!any_in) begin
          mode_d = MODE_SLEEP;
        end
      end
      default: begin
        mode_d = MODE_SLEEP;
      end
    endcase
    // channels wait out the transition latency
    if (mode_d != mode_q) begin
      settle_d = CW'(SETTLE); // (R13)
    end else if (settle_q != '0) begin
      settle_d = settle_q - CW'(1);
    end else begin
      settle_d = settle_q;
    end
    limp_first_d = limp_first_q;
    if (mode_d == MODE_LIMP && mode_q != MODE_LIMP) begin
      limp_first_d = 1'b1;
    end else if (serial_command) begin
      limp_first_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_q <= MODE_SLEEP;
      settle_q <= '0;
      limp_first_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      settle_q <= settle_d;
      limp_first_q <= limp_first_d;
    end
  end

  always_comb begin
    cmd_reset = reg_write && wr_reset_command_bit && mode_q != MODE_LIMP;
    bank_reset = !vdd_ok_s || !idle_s || mode_q == MODE_SLEEP; // (R14) (R21)
    wr_ok = reg_write && vdd_ok_s && !bank_reset &&
      mode_q != MODE_LIMP; // (R6)
    out_on_d = out_on_q;
    act_d = act_q;
    map_a_d = map_a_q;
    map_b_d = map_b_q;
    open_load_off_bits_d = open_load_off_bits_q;
    if (wr_ok) begin
      out_on_d = wr_output_on_bits;
      act_d = wr_stay_active_bit;
      map_a_d = wr_input_map_reg_a;
      map_b_d = wr_input_map_reg_b;
      open_load_off_bits_d = wr_open_load_off_bits;
    end
    if (bank_reset || cmd_reset || mode_q == MODE_LIMP) begin // (R10) (R14)
      out_on_d = `OUTPUT_ON_DEFAULT;
      act_d = 1'b0;
      map_a_d = `MAP_A_DEFAULT; // (R17)
      map_b_d = `MAP_B_DEFAULT; // (R17)
      open_load_off_bits_d = `OPEN_LOAD_OFF_DEFAULT; // (R7)
    end
    // error bits only gather; only the reset input clears them
    err_d = err_q | channel_error_set; // (R15) (R22)
    // supply flags: a new event wins over the readout clear
    uv_d = uv_q;
    if (diag_readout && vs_op_s) begin
      uv_d = 1'b0; // (R19)
    end
    if (cmd_reset) begin
      uv_d = `FLAG_DEFAULT; // (R16)
    end
    if (mode_q != MODE_SLEEP && vs_uv_s) begin
      uv_d = 1'b1; // (R18)
    end
    lop_d = lop_q;
    if (diag_readout && !vdd_lop_s) begin
      lop_d = 1'b0; // (R20)
    end
    if (cmd_reset) begin
      lop_d = `FLAG_DEFAULT; // (R16)
    end
    if (vdd_lop_s) begin
      lop_d = 1'b1; // (R20)
    end
    if (mode_d == MODE_LIMP) begin
      uv_d = 1'b1; // (R7)
      lop_d = 1'b1; // (R7)
    end
    ter_d = ter_q;
    if (serial_command) begin
      ter_d = transmission_error_event || (limp_first_q &&
        mode_q == MODE_LIMP); // (R9)
    end
    chan_d = '0;
    if (settle_q == '0) begin
      case (mode_q)
        MODE_ACTIVE: begin
          chan_d = out_on_q | map_inputs(in_s, map_a_q, map_b_q); // (R17)
        end
        MODE_LIMP: begin
          chan_d = map_inputs(in_s, `MAP_A_DEFAULT, `MAP_B_DEFAULT) &
            `LIMP_CHANNEL_MASK; // (R5) (R11)
        end
        default: begin
          chan_d = '0; // (R21) (R22)
        end
      endcase
    end
    // status field follows the mode register edge for edge
    case (mode_d)
      MODE_LIMP: field_d = `MODE_FIELD_LIMP; // (R8)
      MODE_ACTIVE: field_d = `MODE_FIELD_ACTIVE;
      MODE_IDLE: field_d = `MODE_FIELD_IDLE;
      default: field_d = `MODE_FIELD_SLEEP;
    endcase
    rst_d = bank_reset;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_on_q <= `OUTPUT_ON_DEFAULT;
      act_q <= 1'b0;
      map_a_q <= `MAP_A_DEFAULT;
      map_b_q <= `MAP_B_DEFAULT;
      open_load_off_bits_q <= `OPEN_LOAD_OFF_DEFAULT;
      err_q <= '0;
      uv_q <= `FLAG_DEFAULT;
      lop_q <= `FLAG_DEFAULT;
      ter_q <= 1'b0;
      chan_q <= '0;
      field_q <= `MODE_FIELD_SLEEP;
      rst_q <= 1'b1;
    end else begin
      out_on_q <= out_on_d;
      act_q <= act_d;
      map_a_q <= map_a_d;
      map_b_q <= map_b_d;
      open_load_off_bits_q <= open_load_off_bits_d;
      err_q <= err_d;
      uv_q <= uv_d;
      lop_q <= lop_d;
      ter_q <= ter_d;
      chan_q <= chan_d;
      field_q <= field_d;
      rst_q <= rst_d;
    end
  end

  // outputs straight from flip-flops
  assign mode = mode_q;
  assign mode_field = field_q;
  assign channel_on = chan_q;
  assign output_on_bits = out_on_q;
  assign stay_active_bit = act_q;
  assign input_map_reg_a = map_a_q;
  assign input_map_reg_b = map_b_q;
  assign open_load_off_bits = open_load_off_bits_q;
  assign channel_error_bits = err_q;
  assign output_status_monitor_bits = chan_q; // (R10)
  assign supply_undervoltage_flag = uv_q;
  assign logic_low_operating_flag = lop_q;
  assign transmission_error_flag = ter_q;
  assign regs_in_reset = rst_q;
endmodule // supply_mode_controller

// *** test/supply_mode_props.sv ***
`timescale 1ns/1ps
`include "supply_mode_regs.svh"
module supply_mode_props
  import supply_mode_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int INPUTS = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic idle_pin,
  input wire logic [INPUTS-1:0] parallel_input_pins,
  input wire logic reg_write,
  input wire logic wr_reset_command_bit,
  input wire logic analog_supply_uv,
  input wire logic logic_low_operating,
  input wire logic [CHANNELS-1:0] channel_error_set,
  input wire supply_mode_pkg::op_mode_t mode,
  input wire logic [1:0] mode_field,
  input wire logic [CHANNELS-1:0] channel_on,
  input wire logic [CHANNELS-1:0] output_on_bits,
  input wire logic stay_active_bit,
  input wire logic [CHANNELS-1:0] input_map_reg_a,
  input wire logic [CHANNELS-1:0] open_load_off_bits,
  input wire logic [CHANNELS-1:0] channel_error_bits,
  input wire logic [CHANNELS-1:0] output_status_monitor_bits,
  input wire logic supply_undervoltage_flag,
  input wire logic logic_low_operating_flag,
  input wire logic regs_in_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_limp_status: assert property (
    mode == MODE_LIMP |-> mode_field == `MODE_FIELD_LIMP &&
      supply_undervoltage_flag && logic_low_operating_flag &&
      open_load_off_bits == 0) else $error("limp status wrong");
  a_limp_channels: assert property (
    (mode == MODE_LIMP)[*8] |-> (channel_on & ~`LIMP_CHANNEL_MASK) == 0)
    else $error("limp drives wrong channel");
  a_limp_regs: assert property (
    (mode == MODE_LIMP)[*4] |-> output_on_bits == 0 && !stay_active_bit &&
      input_map_reg_a == `MAP_A_DEFAULT) else $error("limp regs not default");
  a_sleep_off: assert property (
    (mode == MODE_SLEEP)[*4] |-> channel_on == 0 && regs_in_reset)
    else $error("sleep not off");
  a_monitor_match: assert property (
    output_status_monitor_bits == channel_on) else $error("monitor differs");
  a_error_sticky: assert property (
    1 |=> &(channel_error_bits | ~$past(channel_error_bits | channel_error_set)))
    else $error("error bit lost");
  a_active_entry: assert property (
    (idle_pin && |parallel_input_pins)[*7] |-> mode == MODE_ACTIVE)
    else $error("no active mode");
  a_limp_entry: assert property (
    (!idle_pin && |parallel_input_pins)[*7] |-> mode == MODE_LIMP)
    else $error("no limp mode");
  a_idle_return: assert property (
    (idle_pin && parallel_input_pins == 0 && output_on_bits == 0 &&
      !stay_active_bit)[*5] |-> mode == MODE_IDLE) else $error("no idle");
  a_flags_cleared: assert property (
    (!analog_supply_uv && !logic_low_operating)[*4] ##0 (reg_write &&
      wr_reset_command_bit && mode == MODE_ACTIVE) |=>
      !supply_undervoltage_flag && !logic_low_operating_flag)
    else $error("flags kept");
  a_settle_off: assert property (
    $changed(mode) |=> (channel_on == 0)[*5])
    else $error("channel on during mode change");
endmodule // supply_mode_props

bind supply_mode_controller supply_mode_props #(
  .CHANNELS(CHANNELS), .INPUTS(INPUTS)) supply_mode_props_inst (.*);

// *** test/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic idle_pin,
  output logic [1:0] parallel_input_pins,
  output logic reg_write,
  output logic [7:0] wr_output_on_bits,
  output logic wr_stay_active_bit,
  output logic wr_reset_command_bit,
  output logic [7:0] wr_input_map_reg_a,
  output logic [7:0] wr_input_map_reg_b,
  output logic [7:0] wr_open_load_off_bits,
  output logic serial_command,
  output logic diag_readout
);
  initial begin
    {idle_pin, parallel_input_pins, reg_write, serial_command} = '0;
    diag_readout = 1'b0;
    {wr_output_on_bits, wr_stay_active_bit, wr_reset_command_bit} = '0;
    {wr_input_map_reg_a, wr_input_map_reg_b, wr_open_load_off_bits} = '0;
  end
  task automatic pins(input logic i, input logic [1:0] p);
    @(posedge clk);
    idle_pin <= i;
    parallel_input_pins <= p;
  endtask
  // all fields go with one strobe; data scrambled once released
  task automatic wr(input logic [7:0] o, input logic s, r,
                    input logic [7:0] a, b, l);
    @(posedge clk);
    reg_write <= 1'b1;
    {wr_output_on_bits, wr_stay_active_bit, wr_reset_command_bit,
     wr_input_map_reg_a, wr_input_map_reg_b, wr_open_load_off_bits}
      <= {o, s, r, a, b, l};
    @(posedge clk);
    reg_write <= 1'b0;
    {wr_output_on_bits, wr_stay_active_bit, wr_reset_command_bit,
     wr_input_map_reg_a, wr_input_map_reg_b, wr_open_load_off_bits}
      <= ~{o, s, r, a, b, l};
  endtask
  // callers send commands only once the mode has settled
  task automatic cmd(input logic d);
    @(posedge clk);
    serial_command <= ~d;
    diag_readout <= d;
    @(posedge clk);
    serial_command <= 1'b0;
    diag_readout <= 1'b0;
  endtask
endmodule // host_model

// *** test/supply_mode_controller_tb_top.sv ***
`timescale 1ns/1ps
`include "supply_mode_regs.svh"
module supply_mode_controller_tb_top;
  import supply_mode_pkg::*;
  logic clk, reset, logic_supply_ok, logic_low_operating, analog_supply_uv;
  logic analog_supply_op, transmission_error_event, idle_pin, reg_write;
  logic wr_stay_active_bit, wr_reset_command_bit, serial_command;
  logic diag_readout, stay_active_bit, supply_undervoltage_flag;
  logic logic_low_operating_flag, transmission_error_flag, regs_in_reset;
  logic [1:0] parallel_input_pins, mode_field, p;
  chan_vec_t wr_output_on_bits, wr_input_map_reg_a, wr_input_map_reg_b;
  chan_vec_t wr_open_load_off_bits, channel_error_set, channel_on, o;
  chan_vec_t output_on_bits, input_map_reg_a, input_map_reg_b;
  chan_vec_t open_load_off_bits, channel_error_bits;
  chan_vec_t output_status_monitor_bits;
  op_mode_t mode, pm;
  int bad_count = 0, n_checks = 0, cycles = 0, seed = 53, r;
  host_model host_model_inst (.*);
  supply_mode_controller supply_mode_controller_inst (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, e, input string m);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic op_mode_t exp_mode(logic i, logic [1:0] q, chan_vec_t v,
                                        logic s, op_mode_t last);
    if (!i) return (q != 0) ? MODE_LIMP : MODE_SLEEP;
    return (q != 0 || v != 0 || (s && last == MODE_ACTIVE)) ? MODE_ACTIVE :
      MODE_IDLE;
  endfunction
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {logic_supply_ok, analog_supply_op, reset} = 3'b111;
    {logic_low_operating, analog_supply_uv, transmission_error_event} = '0;
    channel_error_set = 8'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    settle(1);
    chk(input_map_reg_b, `MAP_B_DEFAULT, "map default");
    host_model_inst.pins(1'b1, 2'b00);
    settle(8);
    pm = MODE_IDLE;
    repeat (24) begin
      r = $random(seed);
      o = r[3] ? r[15:8] : 8'h00;
      p = r[1:0];
      host_model_inst.wr(o, r[4], 1'b0, 8'h00, 8'h00, 8'h00);
      host_model_inst.pins(1'b1, p);
      settle(10);
      pm = exp_mode(1'b1, p, o, r[4], pm);
      chk(mode, pm, "mode");
      chk(channel_on, (pm == MODE_ACTIVE) ? o : 8'h00, "drive");
    end
    for (int k = 1; k < 4; k++) begin
      host_model_inst.pins(1'b0, k[1:0]);
      settle(12);
      chk(mode_field, `MODE_FIELD_LIMP, "limp field");
      chk(channel_on, {4'h0, k[1:0], 2'b00}, "limp drive");
      chk(supply_undervoltage_flag & logic_low_operating_flag, 1, "lf");
      host_model_inst.wr(8'hFF, 1'b1, 1'b0, 8'hFF, 8'hFF, 8'hFF);
      settle(2);
      chk(output_on_bits | open_load_off_bits, 8'h00, "limp write");
    end
    host_model_inst.cmd(1'b0);
    #1;
    chk(transmission_error_flag, 1'b1, "ter first");
    host_model_inst.cmd(1'b0);
    #1;
    chk(transmission_error_flag, 1'b0, "ter later");
    @(posedge clk);
    transmission_error_event <= 1'b1;
    host_model_inst.cmd(1'b0);
    #1;
    chk(transmission_error_flag, 1'b1, "ter event");
    @(posedge clk);
    transmission_error_event <= 1'b0;
    host_model_inst.pins(1'b1, 2'b01);
    settle(12);
    host_model_inst.wr(8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    settle(8);
    chk(channel_on, 8'h00, "unmapped input");
    chk(mode, MODE_ACTIVE, "unmapped active");
    @(posedge clk);
    channel_error_set <= 8'h81;
    @(posedge clk);
    channel_error_set <= 8'h00;
    host_model_inst.wr(8'h00, 1'b0, 1'b1, 8'h00, 8'h00, 8'h00);
    settle(8);
    chk({supply_undervoltage_flag, logic_low_operating_flag}, 0, "f");
    chk(channel_error_bits, 8'h81, "errors kept");
    chk(channel_on, `MAP_A_DEFAULT, "held by input");
    @(posedge clk);
    {analog_supply_uv, analog_supply_op, logic_low_operating} <= 3'b101;
    settle(6);
    chk(supply_undervoltage_flag, 1'b1, "uv set");
    chk(logic_low_operating_flag, 1'b1, "lop set");
    @(posedge clk);
    {analog_supply_uv, logic_low_operating} <= 2'b00;
    settle(6);
    chk(logic_low_operating_flag, 1'b1, "lop held");
    host_model_inst.cmd(1'b1);
    #1;
    chk(supply_undervoltage_flag, 1'b1, "uv early clear");
    @(posedge clk);
    analog_supply_op <= 1'b1;
    settle(6);
    host_model_inst.cmd(1'b1);
    #1;
    chk(supply_undervoltage_flag, 1'b0, "uv clear");
    chk(logic_low_operating_flag, 1'b0, "lop clear");
    host_model_inst.wr(8'h30, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
    settle(2);
    chk(output_on_bits, 8'h30, "written");
    @(posedge clk);
    logic_supply_ok <= 1'b0;
    settle(6);
    chk(output_on_bits | {7'h0, stay_active_bit}, 8'h00, "uv reset");
    @(posedge clk);
    logic_supply_ok <= 1'b1;
    host_model_inst.pins(1'b0, 2'b00);
    settle(10);
    chk(mode, MODE_SLEEP, "sleep");
    chk({channel_on[6:0], regs_in_reset}, 8'h01, "sleep off");
    stop_test();
  end
endmodule // supply_mode_controller_tb_top
